/* hw/irq_unit_pkg.sv */
package irq_unit_pkg;
  localparam logic [7:0] second_request_flags_addr = 8'h07;
  localparam logic [7:0] first_request_enables_addr = 8'h08;
  localparam logic [7:0] second_request_enables_addr = 8'h09;
  localparam logic [7:0] link_error_flags_addr = 8'h0a;
  localparam logic [7:0] first_request_flags_addr = 8'h06;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam int set_bit = 7;
  localparam int global_bit = 6;
  localparam int inv_bit = 7;
  localparam int push_pull_bit = 7;
  localparam int pin_gate_bit = 6;
  localparam int eeprom_err_bit = 7;
  localparam int misuse_err_bit = 6;
  localparam int overflow_err_bit = 5;
  localparam int summary_bit = 1;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [6:0] first_flags;
    logic [6:0] first_set;
    logic [5:0] second_set;
    logic eeprom_error;
    logic eeprom_done;
    logic buffer_write;
    logic buffer_full;
    logic write_forbidden;
    logic command_start;
    logic multi_frame_receive;
    logic errors_stored;
    logic [2:0] other_errors;
  } events_s;

  typedef struct packed {
    logic drive;
    logic level;
    logic oe;
  } pin_s;
endpackage

/* hw/irq_pin_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic global_active,
  input wire logic pin_output_gate,
  input wire logic invert,
  input wire logic pin_push_pull_select,
  output var irq_unit_pkg::pin_s pin
);
  irq_unit_pkg::pin_s state;
  irq_unit_pkg::pin_s next_state;
  logic level;

  always_comb
  begin
    level = (global_active & pin_output_gate) ^ invert;
    next_state.drive = level;
    next_state.level = level;
    // open-drain can only pull low
    next_state.oe = pin_push_pull_select | ~level;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign pin = state;

  pin_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!$past(pin_push_pull_select) && $past(level)) |-> !pin.oe)
    else $error("open drain pin driven high");
endmodule
`default_nettype wire

/* hw/reader_frontend_irq_error_unit.sv */
// Functional notes
// - second request write: bit7 sets or clears
// - global flag on any enabled active flag
// - card detect sets bit 5
// - timer underflows set bits 4 to 0
// - first enable bit7 inverts pin
// - first enables gate first flags globally
// - second enables gate card and timer flags
// - bit7 push-pull else open-drain pin
// - pin follows global only when gated
// - eeprom failure sets error bit 7
// - forbidden buffer write sets error bit 6
// - bit 6 cleared at command start outside multi-frame receive, or at errors stored in multi-frame receive
// - full buffer write sets bit 5, ignore
// - first request register same set/clear
// - buffer errors or link error bits 1 to 0 set summary flag
`timescale 1ns/1ps
`default_nettype none
module reader_frontend_irq_error_unit
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire irq_unit_pkg::reg_req_s req,
  input wire irq_unit_pkg::events_s ev,
  output logic [7:0] rdata,
  output logic buffer_accept,
  output logic pin_out,
  output logic pin_oe
);
  typedef struct packed {
    logic [6:0] first_flags;
    logic [6:0] second_flags;
    logic [7:0] first_en;
    logic [7:0] second_en;
    logic [7:0] errors;
    logic [7:0] rdata;
    logic buffer_accept;
  } state_s;

  state_s state;
  state_s next_state;
  irq_unit_pkg::pin_s pin;
  logic active;
  logic [6:0] second_view;
  logic write_first;
  logic write_second;
  logic new_error;
  logic drop;

  always_comb
  begin
    next_state = state;
    write_first = req.wr && req.addr == irq_unit_pkg::first_request_flags_addr;
    write_second = req.wr && req.addr == irq_unit_pkg::second_request_flags_addr;
    // host write first, hardware sets after so a same-cycle event wins
    if (write_first)
    begin
      if (req.wdata[irq_unit_pkg::set_bit])
        next_state.first_flags = state.first_flags | req.wdata[6:0];
      else
        next_state.first_flags = state.first_flags & ~req.wdata[6:0];
    end
    if (write_second)
    begin
      if (req.wdata[irq_unit_pkg::set_bit])
        next_state.second_flags[5:0] = state.second_flags[5:0] | req.wdata[5:0];
      else
        next_state.second_flags[5:0] = state.second_flags[5:0] & ~req.wdata[5:0];
    end
    if (req.wr && req.addr == irq_unit_pkg::first_request_enables_addr)
      next_state.first_en = req.wdata;
    if (req.wr && req.addr == irq_unit_pkg::second_request_enables_addr)
      next_state.second_en = req.wdata;
    // error flags
    if (ev.eeprom_done)
      next_state.errors[irq_unit_pkg::eeprom_err_bit] = ev.eeprom_error;
    if (ev.multi_frame_receive ? ev.errors_stored : ev.command_start)
      next_state.errors[irq_unit_pkg::misuse_err_bit] = 1'b0;
    // overflow flag locks out all later writes until a new command clears it
    drop = state.errors[irq_unit_pkg::overflow_err_bit] | ev.buffer_full;
    if (ev.command_start)
      next_state.errors[irq_unit_pkg::overflow_err_bit] = 1'b0;
    if (ev.buffer_write && ev.write_forbidden)
      next_state.errors[irq_unit_pkg::misuse_err_bit] = 1'b1;
    if (ev.buffer_write && ev.buffer_full)
      next_state.errors[irq_unit_pkg::overflow_err_bit] = 1'b1;
    next_state.errors[2:0] = ev.other_errors;
    next_state.buffer_accept = ev.buffer_write && !drop;
    // collision alone does not raise the summary flag
    new_error = (next_state.errors[6] & ~state.errors[6])
      | (next_state.errors[5] & ~state.errors[5])
      | |(ev.other_errors[1:0] & ~state.errors[1:0]);
    next_state.first_flags = next_state.first_flags | ev.first_set
      | (new_error ? 7'h02 : 7'h00);
    next_state.second_flags[5:0] = next_state.second_flags[5:0] | ev.second_set;
    active = |(next_state.first_flags & next_state.first_en[6:0])
      | |(next_state.second_flags[5:0] & next_state.second_en[5:0]);
    next_state.second_flags[irq_unit_pkg::global_bit] = active;
    second_view = state.second_flags;
    unique case (req.addr)
      irq_unit_pkg::first_request_flags_addr: next_state.rdata = {1'b0, state.first_flags};
      irq_unit_pkg::second_request_flags_addr: next_state.rdata = {1'b0, second_view};
      irq_unit_pkg::first_request_enables_addr: next_state.rdata = state.first_en;
      irq_unit_pkg::second_request_enables_addr: next_state.rdata = state.second_en;
      irq_unit_pkg::link_error_flags_addr: next_state.rdata = state.errors;
      default: next_state.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state <= '0;
    else
      state <= next_state;
  end

  irq_pin_driver pin_drv
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .global_active(state.second_flags[irq_unit_pkg::global_bit]),
    .pin_output_gate(state.second_en[irq_unit_pkg::pin_gate_bit]),
    .invert(state.first_en[irq_unit_pkg::inv_bit]),
    .pin_push_pull_select(state.second_en[irq_unit_pkg::push_pull_bit]),
    .pin(pin)
  );

  assign rdata = state.rdata;
  assign buffer_accept = state.buffer_accept;
  assign pin_out = pin.drive;
  assign pin_oe = pin.oe;

  sequence set_write;
    write_second && req.wdata[7] && req.wdata[0];
  endsequence
  // hardware sets win, so the clear checks leave out same-cycle events
  sequence first_clear_write;
    write_first && !req.wdata[7] && req.wdata[0] && !ev.first_set[0];
  endsequence
  sequence forbidden_write;
    ev.buffer_write && ev.write_forbidden;
  endsequence

  set_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    set_write |=> state.second_flags[0])
    else $error("set write lost");
  clear_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (write_second && !req.wdata[7] && req.wdata[1] && !ev.second_set[1])
      |=> !state.second_flags[1])
    else $error("clear write lost");
  first_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (write_first && req.wdata[7] && req.wdata[0]) |=> state.first_flags[0])
    else $error("first set write lost");
  first_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    first_clear_write |=> !state.first_flags[0])
    else $error("first clear write lost");
  timer_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ev.second_set[4] |=> state.second_flags[4])
    else $error("timer flag not set");
  timer_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ev.second_set[0] |=> state.second_flags[0])
    else $error("timer zero flag not set");
  card_detect_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ev.second_set[5] |=> state.second_flags[5])
    else $error("card detect flag not set");
  global_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.second_set[0] && state.second_en[0]
      && !(req.wr && req.addr == irq_unit_pkg::second_request_enables_addr))
      |=> state.second_flags[6])
    else $error("global flag not raised");
  first_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state.first_flags[2] && state.first_en[2]) |-> state.second_flags[6])
    else $error("first enable not gated");
  second_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state.second_flags[5] && state.second_en[5]) |-> state.second_flags[6])
    else $error("second enable not gated");
  global_or_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state.second_flags[6] == (|(state.first_flags & state.first_en[6:0])
      | |(state.second_flags[5:0] & state.second_en[5:0])))
    else $error("global flag mismatch");
  pin_level_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 pin_out == $past((state.second_flags[6] & state.second_en[6]) ^ state.first_en[7]))
    else $error("pin level wrong");
  pin_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !state.second_en[6] |=> pin_out == $past(state.first_en[7]))
    else $error("pin not gated");
  pin_invert_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state.first_en[7] && !state.second_flags[6]) |=> pin_out)
    else $error("pin not inverted");
  push_pull_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state.second_en[7] |=> pin_oe)
    else $error("push pull pin released");
  eeprom_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ev.eeprom_done |=> state.errors[7] == $past(ev.eeprom_error))
    else $error("eeprom error not loaded");
  eeprom_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !ev.eeprom_done |=> $stable(state.errors[7]))
    else $error("eeprom error changed");
  misuse_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    forbidden_write |=> state.errors[6])
    else $error("misuse not flagged");
  misuse_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.command_start && !ev.multi_frame_receive && !ev.buffer_write) |=> !state.errors[6])
    else $error("misuse not cleared");
  stored_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.errors_stored && ev.multi_frame_receive && !ev.buffer_write) |=> !state.errors[6])
    else $error("misuse not cleared after store");
  overflow_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.buffer_write && ev.buffer_full) |=> state.errors[5] && !buffer_accept)
    else $error("overflow not flagged");
  overflow_drop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.buffer_write && state.errors[5]) |=> !buffer_accept)
    else $error("write after overflow accepted");
  overflow_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (state.errors[5] && !ev.command_start) |=> state.errors[5])
    else $error("overflow flag lost");
  summary_flag_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.buffer_write && ev.buffer_full && !state.errors[5]) |=> state.first_flags[1])
    else $error("summary flag not set");
  summary_misuse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ev.buffer_write && ev.write_forbidden && !state.errors[6]) |=> state.first_flags[1])
    else $error("summary flag not set on misuse");
endmodule
`default_nettype wire

/* sim/host_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_pin_model
(
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic irq_level
);
  // board pull-up holds the line high once released
  assign irq_level = pin_oe ? pin_out : 1'b1;
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0;
  logic resetn = 0;
  irq_unit_pkg::reg_req_s req = '0;
  irq_unit_pkg::events_s ev = '0;
  irq_unit_pkg::events_s lv = '0;
  logic [7:0] rdata;
  logic buffer_accept, pin_out, pin_oe, irq_level;
  int fail_count = 0;
  int n_compared = 0;
  int f0 = 0, f1 = 0, e0 = 0, e1 = 0, er = 0;
  reader_frontend_irq_error_unit uut (.core_clk(core_clk), .resetn(resetn), .req(req),
    .ev(ev), .rdata(rdata), .buffer_accept(buffer_accept), .pin_out(pin_out), .pin_oe(pin_oe));
  host_pin_model host (.pin_out(pin_out), .pin_oe(pin_oe), .irq_level(irq_level));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input int exp);
    n_compared++;
    if (got !== 8'(exp))
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, 8'(exp));
    end
  endtask
  function automatic int glob();
    return ((f0 & e0 & 'h7f) | (f1 & e1 & 'h3f)) != 0;
  endfunction
  function automatic int reg_val(input logic [7:0] a);
    case (a)
      8'h06: return f0;
      8'h07: return f1 | (glob() << 6);
      8'h08: return e0;
      8'h09: return e1;
      8'h0a: return er;
      default: return 0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input int d);
    @(negedge core_clk);
    req.wr = 1;
    req.addr = a;
    req.wdata = 8'(d);
    @(negedge core_clk);
    req.wr = 0;
    case (a)
      8'h06: f0 = d[7] ? f0 | d & 'h7f : f0 & ~d;
      8'h07: f1 = d[7] ? f1 | d & 'h3f : f1 & ~d;
      8'h08: e0 = d & 'hff;
      8'h09: e1 = d & 'hff;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    req.addr = a;
    @(negedge core_clk);
    chk(rdata, reg_val(a));
  endtask
  task automatic pin_chk;
    int lvl;
    repeat (3) @(negedge core_clk);
    lvl = e0[7] ^ (e1[6] & glob());
    chk({7'b0, irq_level}, lvl);
    chk({7'b0, pin_out}, lvl);
    chk({7'b0, pin_oe}, e1[7] | (lvl == 0));
  endtask
  task automatic step(input irq_unit_pkg::events_s e);
    irq_unit_pkg::events_s x;
    int o;
    x = lv | e;
    o = er;
    wr(8'h06, 'h02);
    @(negedge core_clk);
    ev = x;
    @(negedge core_clk);
    ev = lv;
    if (x.buffer_write && !x.write_forbidden)
      chk({7'b0, buffer_accept}, x.buffer_full == 0 && er[5] == 0);
    if (x.eeprom_done)
      er[7] = x.eeprom_error;
    if (x.buffer_write && x.write_forbidden)
      er[6] = 1;
    else if (x.multi_frame_receive ? x.errors_stored : x.command_start)
      er[6] = 0;
    if (x.buffer_write && x.buffer_full)
      er[5] = 1;
    else if (x.command_start)
      er[5] = 0;
    er[2:0] = x.other_errors;
    if ((er & ~o & 'h63) != 0)
      f0 |= 2;
    f0 |= x.first_set;
    f1 |= x.second_set;
    rd(8'h0a);
    rd(8'h06);
    rd(8'h07);
    pin_chk();
  endtask
  initial
  begin
    #200us;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hd8fa_9037));
    repeat (8) @(negedge core_clk);
    resetn = 1;
    wr(8'h0a, 'hff);
    wr(8'h0b, 'hff);
    for (int a = 6; a < 12; a++)
      rd(8'(a));
    $display("reset and map test done");
    for (int i = 0; i < 40; i++)
    begin
      wr(8'(6 + $urandom_range(3)), $urandom);
      rd(8'h07);
      rd(8'h06);
      rd(8'h08);
      pin_chk();
    end
    $display("set and clear test done");
    wr(8'h06, 'h7f);
    wr(8'h07, 'h3f);
    for (int i = 0; i < 7; i++)
      step('{first_set:7'(1 << i), second_set:6'(1 << (i % 6)), default:0});
    $display("event flag test done");
    step('{eeprom_done:1, eeprom_error:1, default:0});
    step('{eeprom_done:1, default:0});
    lv.write_forbidden = 1;
    step('{buffer_write:1, default:0});
    lv.write_forbidden = 0;
    step('{command_start:1, default:0});
    lv.multi_frame_receive = 1;
    lv.write_forbidden = 1;
    step('{buffer_write:1, default:0});
    lv.write_forbidden = 0;
    step('{command_start:1, default:0});
    step('{errors_stored:1, default:0});
    lv.multi_frame_receive = 0;
    lv.buffer_full = 1;
    step('{buffer_write:1, default:0});
    lv.buffer_full = 0;
    step('{buffer_write:1, default:0});
    step('{command_start:1, default:0});
    step('{buffer_write:1, default:0});
    for (int k = 0; k < 8; k++)
    begin
      lv.other_errors = 3'(k);
      step('{default:0});
    end
    $display("error flag test done");
    lv = '0;
    ev = '0;
    resetn = 0;
    repeat (2) @(negedge core_clk);
    chk({6'b0, pin_out, pin_oe}, 0);
    chk(rdata, 0);
    resetn = 1;
    f0 = 0;
    f1 = 0;
    e0 = 0;
    e1 = 0;
    er = 0;
    for (int a = 6; a < 11; a++)
      rd(8'(a));
    pin_chk();
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
